// ===== design/ivt_device.sv
`timescale 1ns/10ps
// Summary of operation
// - Scale word at 29h, unsigned, 0.001 steps
// - Scale word resets to 0x0359 (0.857)
// - Start conversion at turn-on threshold, conditions met
// - Host keeps turn-on between 7.5 and 15 V; ivt_host passes any value, reset is 7.25 V
// - Turn-on word unsigned, 250 mV per bit
// - Turn-on word resets to 0x001D (7.25 V)
// - Host keeps turn-on well above turn-off; ivt_host does not check the margin
// - Running conversion stops at turn-off threshold
// - Host keeps turn-off between 7.25 and 14.75 V; ivt_host passes any value, reset is 6.75 V
// - Host keeps turn-off well below turn-on; ivt_host does not check the margin
module ivt_device (
    input wire logic clk,
    input wire logic reset_n,
    ivt_link_if.device link,
    input wire logic [15:0] vin_level,
    input wire logic power_up_ok,
    output logic convert_on,
    output logic [15:0] scale_word,
    output logic [15:0] vin_on_word,
    output logic [15:0] vin_off_word
);
    import ivt_pkg::*;

    // ------------------------------------------------------------
    // Command stored words
    // ------------------------------------------------------------
    logic [15:0] scale_r;
    logic [15:0] vin_on_r;
    logic [15:0] vin_off_r;
    logic wr_en;
    logic [15:0] wr_val;
    logic code_known;

    // ------------------------------------------------------------
    // Link answer
    // ------------------------------------------------------------
    logic rsp_valid_r;
    logic rsp_err_r;
    logic [15:0] rsp_rdata_r;
    logic [15:0] rd_val;

    // ------------------------------------------------------------
    // Conversion control
    // ------------------------------------------------------------
    ivt_conv_type conv_r;
    ivt_conv_type conv_nxt;
    logic above_on;
    logic at_or_below_off;
    logic convert_on_r;
    logic [15:0] scale_out_r;
    logic [15:0] on_out_r;
    logic [15:0] off_out_r;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    always_comb begin
        code_known = 1'b0;
        case (link.cmd_code)
            IVT_CODE_SCALE: begin
                code_known = 1'b1;
            end
            IVT_CODE_VIN_ON: begin
                code_known = 1'b1;
            end
            IVT_CODE_VIN_OFF: begin
                code_known = 1'b1;
            end
            default: begin
                code_known = 1'b0;
            end
        endcase
    end

    assign wr_en = link.cmd_valid && link.cmd_write && code_known;
    // Upper bits never stored, so they always read back zero
    assign wr_val = link.cmd_wdata & IVT_WR_MASK;

    always_comb begin
        case (link.cmd_code)
            IVT_CODE_SCALE: begin
                rd_val = scale_r;
            end
            IVT_CODE_VIN_ON: begin
                rd_val = vin_on_r;
            end
            IVT_CODE_VIN_OFF: begin
                rd_val = vin_off_r;
            end
            default: begin
                rd_val = 16'h0000;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Scale word
    // ------------------------------------------------------------
    // Unsigned, 0.001 per bit; the value is only held and exported
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scale_r <= IVT_SCALE_RST;
        end else if (wr_en && link.cmd_code == IVT_CODE_SCALE) begin
            scale_r <= wr_val;
        end
    end

    // ------------------------------------------------------------
    // Turn-on threshold
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            vin_on_r <= IVT_VIN_ON_RST;
        end else if (wr_en && link.cmd_code == IVT_CODE_VIN_ON) begin
            vin_on_r <= wr_val;
        end
    end

    // ------------------------------------------------------------
    // Turn-off threshold
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            vin_off_r <= IVT_VIN_OFF_RST;
        end else if (wr_en && link.cmd_code == IVT_CODE_VIN_OFF) begin
            vin_off_r <= wr_val;
        end
    end

    // ------------------------------------------------------------
    // Answer, one cycle after the command
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_valid_r <= 1'b0;
            rsp_err_r <= 1'b0;
            rsp_rdata_r <= 16'h0000;
        end else begin
            rsp_valid_r <= link.cmd_valid;
            if (link.cmd_valid) begin
                rsp_err_r <= !code_known;
                // Reads of unknown codes return zero with the error flag
                rsp_rdata_r <= link.cmd_write ? 16'h0000 : rd_val;
            end
        end
    end

    assign link.rsp_valid = rsp_valid_r;
    assign link.rsp_err = rsp_err_r;
    assign link.rsp_rdata = rsp_rdata_r;

    // ------------------------------------------------------------
    // Conversion state
    // ------------------------------------------------------------
    // Vin level shares the 250 mV per bit scale of both thresholds
    assign above_on = vin_level >= vin_on_r;
    assign at_or_below_off = vin_level <= vin_off_r;

    // No hysteresis of its own: the gap between the two words is it
    always_comb begin
        conv_nxt = conv_r;
        case (conv_r)
            IVT_STOPPED: begin
                if (above_on && power_up_ok) begin
                    conv_nxt = IVT_RUNNING;
                end
            end
            IVT_RUNNING: begin
                if (at_or_below_off) begin
                    conv_nxt = IVT_STOPPED;
                end
            end
            default: begin
                conv_nxt = IVT_STOPPED;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            conv_r <= IVT_STOPPED;
        end else begin
            conv_r <= conv_nxt;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            convert_on_r <= 1'b0;
        end else begin
            convert_on_r <= (conv_nxt == IVT_RUNNING);
        end
    end

    // ------------------------------------------------------------
    // Exported words, registered copies
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scale_out_r <= IVT_SCALE_RST;
            on_out_r <= IVT_VIN_ON_RST;
            off_out_r <= IVT_VIN_OFF_RST;
        end else begin
            scale_out_r <= scale_r;
            on_out_r <= vin_on_r;
            off_out_r <= vin_off_r;
        end
    end

    assign convert_on = convert_on_r;
    assign scale_word = scale_out_r;
    assign vin_on_word = on_out_r;
    assign vin_off_word = off_out_r;
endmodule : ivt_device

// ===== design/ivt_pkg.sv
package ivt_pkg;
    // ------------------------------------------------------------
    // Command codes on the management link
    // ------------------------------------------------------------
    localparam logic [7:0] IVT_CODE_SCALE = 8'h29;
    localparam logic [7:0] IVT_CODE_VIN_ON = 8'h35;
    localparam logic [7:0] IVT_CODE_VIN_OFF = 8'h36;

    // ------------------------------------------------------------
    // Word layout and reset values
    // ------------------------------------------------------------
    localparam int IVT_WORD_W = 16;
    localparam int IVT_CODE_W = 8;
    localparam logic [15:0] IVT_WR_MASK = 16'h07ff;
    localparam logic [15:0] IVT_SCALE_RST = 16'h0359;
    localparam logic [15:0] IVT_VIN_ON_RST = 16'h001d;
    localparam logic [15:0] IVT_VIN_OFF_RST = 16'h001b;
    // Weights: scale 0.001 per bit, thresholds 250 mV per bit
    localparam int IVT_SCALE_LSB_MILLI = 1;
    localparam int IVT_VIN_LSB_MV = 250;

    // ------------------------------------------------------------
    // Host APB register map
    // ------------------------------------------------------------
    localparam logic [7:0] IVT_APB_CMD = 8'h00;
    localparam logic [7:0] IVT_APB_WDATA = 8'h04;
    localparam logic [7:0] IVT_APB_STATUS = 8'h08;
    localparam logic [7:0] IVT_APB_RDATA = 8'h0c;
    localparam int IVT_CMD_WRITE_BIT = 8;
    localparam int IVT_ST_BUSY_BIT = 0;
    localparam int IVT_ST_DONE_BIT = 1;
    localparam int IVT_ST_ERR_BIT = 2;
    localparam int IVT_ST_CONV_BIT = 3;

    // ------------------------------------------------------------
    // State types
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        IVT_STOPPED = 1'b0,
        IVT_RUNNING = 1'b1
    } ivt_conv_type;

    typedef enum logic [1:0] {
        IVT_H_IDLE = 2'b00,
        IVT_H_ISSUE = 2'b01,
        IVT_H_WAIT = 2'b11
    } ivt_host_type;
endpackage : ivt_pkg

// ===== design/ivt_link_if.sv
`timescale 1ns/10ps
interface ivt_link_if;
    logic cmd_valid;
    logic cmd_write;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata;
    logic rsp_valid;
    logic rsp_err;
    logic [15:0] rsp_rdata;

    modport device (
        input cmd_valid,
        input cmd_write,
        input cmd_code,
        input cmd_wdata,
        output rsp_valid,
        output rsp_err,
        output rsp_rdata
    );

    modport host (
        output cmd_valid,
        output cmd_write,
        output cmd_code,
        output cmd_wdata,
        input rsp_valid,
        input rsp_err,
        input rsp_rdata
    );
endinterface : ivt_link_if

// ===== design/ivt_host.sv
`timescale 1ns/10ps
module ivt_host (
    input wire logic clk,
    input wire logic reset_n,
    ivt_link_if.host link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic convert_seen
);
    import ivt_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    ivt_host_type st_r;
    logic [8:0] cmd_r;
    logic [15:0] wdata_r;
    logic [15:0] rdata_r;
    logic done_r;
    logic err_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic apb_wr;
    logic apb_rd;
    logic known;
    logic start;

    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && penable && !pwrite;
    assign known = paddr == IVT_APB_CMD || paddr == IVT_APB_WDATA ||
                   paddr == IVT_APB_STATUS || paddr == IVT_APB_RDATA;
    // Commands written while busy are dropped
    assign start = apb_wr && paddr == IVT_APB_CMD && st_r == IVT_H_IDLE;

    // ------------------------------------------------------------
    // APB slave, zero wait states
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_r <= 9'h000;
            wdata_r <= 16'h0000;
        end else begin
            if (start) begin
                cmd_r <= pwdata[8:0];
            end
            if (apb_wr && paddr == IVT_APB_WDATA) begin
                wdata_r <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pslverr_r <= psel && !penable && !known;
            prdata_r <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    IVT_APB_CMD: begin
                        prdata_r <= {23'h000000, cmd_r};
                    end
                    IVT_APB_WDATA: begin
                        prdata_r <= {16'h0000, wdata_r};
                    end
                    IVT_APB_STATUS: begin
                        prdata_r <= {28'h0000000, convert_seen, err_r, done_r,
                                     st_r != IVT_H_IDLE};
                    end
                    IVT_APB_RDATA: begin
                        prdata_r <= {16'h0000, rdata_r};
                    end
                    default: begin
                        prdata_r <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = pslverr_r;

    // ------------------------------------------------------------
    // Link sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= IVT_H_IDLE;
        end else begin
            case (st_r)
                IVT_H_IDLE: begin
                    if (start) begin
                        st_r <= IVT_H_ISSUE;
                    end
                end
                IVT_H_ISSUE: begin
                    st_r <= IVT_H_WAIT;
                end
                IVT_H_WAIT: begin
                    if (link.rsp_valid) begin
                        st_r <= IVT_H_IDLE;
                    end
                end
                default: begin
                    st_r <= IVT_H_IDLE;
                end
            endcase
        end
    end

    // Done is set by the answer and cleared by a new start
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            done_r <= 1'b0;
            err_r <= 1'b0;
            rdata_r <= 16'h0000;
        end else if (st_r == IVT_H_WAIT && link.rsp_valid) begin
            done_r <= 1'b1;
            err_r <= link.rsp_err;
            rdata_r <= link.rsp_rdata;
        end else if (start) begin
            done_r <= 1'b0;
            err_r <= 1'b0;
        end
    end

    // Range and margin of threshold values are left to software
    assign link.cmd_valid = st_r == IVT_H_ISSUE;
    assign link.cmd_write = cmd_r[IVT_CMD_WRITE_BIT];
    assign link.cmd_code = cmd_r[7:0];
    assign link.cmd_wdata = wdata_r;
endmodule : ivt_host

// ===== verif/ivt_link_monitor.sv
`timescale 1ns/10ps
module ivt_link_monitor (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic rsp_valid,
    input wire logic rsp_err,
    input wire logic [15:0] rsp_rdata
);
    import ivt_pkg::*;
    // ------------------------------------------------------------
    // Shadow of stored words
    // ------------------------------------------------------------
    // Kept from link traffic alone, so no design state is peeked
    logic [15:0] sc_r;
    logic [15:0] on_r;
    logic [15:0] off_r;
    logic known;
    assign known = cmd_code inside {8'h29, 8'h35, 8'h36};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sc_r <= 16'h0359;
            on_r <= 16'h001d;
            off_r <= 16'h001b;
        end else if (cmd_valid && cmd_write) begin
            if (cmd_code == 8'h29) sc_r <= cmd_wdata & 16'h07ff;
            if (cmd_code == 8'h35) on_r <= cmd_wdata & 16'h07ff;
            if (cmd_code == 8'h36) off_r <= cmd_wdata & 16'h07ff;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_rd(logic [7:0] c);
        cmd_valid && !cmd_write && cmd_code == c;
    endsequence

    a_answer_one_cycle: assert property (cmd_valid |=> rsp_valid)
        else $error("answer not one cycle after command");
    a_no_stray_answer: assert property (rsp_valid |-> $past(cmd_valid))
        else $error("answer without command");
    a_unknown_code_err: assert property (
        cmd_valid && !known |=> rsp_err && rsp_rdata == 16'h0)
        else $error("unknown code not refused");
    a_known_code_ok: assert property (cmd_valid && known |=> !rsp_err)
        else $error("known code refused");
    a_write_rdata_zero: assert property (cmd_valid && cmd_write |=> rsp_rdata == 16'h0)
        else $error("write answer carries data");
    a_scale_read_back: assert property (s_rd(8'h29) |=> rsp_rdata == $past(sc_r))
        else $error("scale word read mismatch");
    a_on_read_back: assert property (s_rd(8'h35) |=> rsp_rdata == $past(on_r))
        else $error("turn-on word read mismatch");
    a_off_read_back: assert property (s_rd(8'h36) |=> rsp_rdata == $past(off_r))
        else $error("turn-off word read mismatch");
    a_upper_bits_zero: assert property (rsp_valid |-> rsp_rdata[15:11] == 5'h00)
        else $error("upper bits not zero");
endmodule : ivt_link_monitor

// ===== verif/testbench.sv
`timescale 1ns/10ps
module testbench;
    import ivt_pkg::*;
    logic clk = 1'b0;
    logic reset_n, psel, penable, pwrite, pready, pslverr, power_up_ok, convert_on, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] vin_level, scale_word, vin_on_word, vin_off_word;
    logic [7:0] codes [3] = '{8'h29, 8'h35, 8'h36};
    logic [15:0] rst [3] = '{16'h0359, 16'h001d, 16'h001b};
    // Upper bits set, low bits kept inside each threshold's legal range
    logic [15:0] wv [3] = '{16'hffff, 16'hf83c, 16'hf830};
    logic [15:0] ev [3] = '{16'h07ff, 16'h003c, 16'h0030};
    // Steps: power_up_ok, input level, expected conversion state
    logic [17:0] steps [6] = '{{1'b0, 16'h0030, 1'b0}, {1'b1, 16'h0027, 1'b0},
        {1'b1, 16'h0028, 1'b1}, {1'b0, 16'h0025, 1'b1}, {1'b0, 16'h0024, 1'b0},
        {1'b1, 16'h0027, 1'b0}};
    int fails = 0;
    int compares = 0;

    always #25 clk = ~clk;

    ivt_link_if link();
    ivt_device u_ivt_device (.clk(clk), .reset_n(reset_n), .link(link),
        .vin_level(vin_level), .power_up_ok(power_up_ok), .convert_on(convert_on),
        .scale_word(scale_word), .vin_on_word(vin_on_word), .vin_off_word(vin_off_word));
    ivt_host u_ivt_host (.clk(clk), .reset_n(reset_n), .link(link), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .convert_seen(convert_on));
    ivt_link_monitor u_ivt_link_monitor (.clk(clk), .reset_n(reset_n),
        .cmd_valid(link.cmd_valid), .cmd_write(link.cmd_write), .cmd_code(link.cmd_code),
        .cmd_wdata(link.cmd_wdata), .rsp_valid(link.rsp_valid), .rsp_err(link.rsp_err),
        .rsp_rdata(link.rsp_rdata));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task stop_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Waits on pready alone; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    // No fixed answer time assumed: status is polled until done
    task link_op(input logic w, input logic [7:0] c, input logic [15:0] d,
                 output logic [31:0] q, output logic e);
        logic [31:0] s;
        logic x;
        apb(1'b1, IVT_APB_WDATA, {16'h0000, d}, s, x);
        apb(1'b1, IVT_APB_CMD, {23'h0, w, c}, s, x);
        do begin
            apb(1'b0, IVT_APB_STATUS, 32'h0, s, x);
        end while (s[1:0] !== 2'b10);
        e = s[IVT_ST_ERR_BIT];
        apb(1'b0, IVT_APB_RDATA, 32'h0, q, x);
    endtask : link_op

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        vin_level = 16'h0000;
        power_up_ok = 1'b0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        chk({vin_on_word, vin_off_word}, 32'h001d001b);
        chk({16'h0, scale_word}, 32'h0359);
        for (int i = 0; i < 3; i++) begin
            link_op(1'b0, codes[i], 16'h0000, rd, err);
            chk(rd, {16'h0, rst[i]});
            chk({31'h0, err}, 32'h0);
            link_op(1'b1, codes[i], wv[i], rd, err);
            link_op(1'b0, codes[i], 16'h0000, rd, err);
            chk(rd, {16'h0, ev[i]});
        end
        link_op(1'b0, 8'h4a, 16'h0000, rd, err);
        chk({err, rd[30:0]}, 32'h80000000);
        apb(1'b0, 8'h10, 32'h0, rd, err);
        chk({31'h0, err}, 32'h1);
        // On at 10 V, off at 9 V: inside limits with 1 V margin
        link_op(1'b1, 8'h35, 16'h0028, rd, err);
        link_op(1'b1, 8'h36, 16'h0024, rd, err);
        link_op(1'b1, 8'h29, 16'h03e8, rd, err);
        link_op(1'b0, 8'h29, 16'h0000, rd, err);
        chk(rd, 32'h03e8);
        chk({vin_on_word, vin_off_word}, 32'h00280024);
        for (int i = 0; i < 6; i++) begin
            power_up_ok <= steps[i][17];
            vin_level <= steps[i][16:1];
            repeat (3) @(posedge clk);
            chk({31'h0, convert_on}, {31'h0, steps[i][0]});
            apb(1'b0, IVT_APB_STATUS, 32'h0, rd, err);
            chk({31'h0, rd[IVT_ST_CONV_BIT]}, {31'h0, steps[i][0]});
        end
        // Mid-run reset: running stops, words fall back, start uses reset threshold
        power_up_ok <= 1'b1;
        vin_level <= 16'h0030;
        repeat (3) @(posedge clk);
        chk({31'h0, convert_on}, 32'h1);
        reset_n <= 1'b0;
        @(posedge clk);
        chk({31'h0, convert_on}, 32'h0);
        reset_n <= 1'b1;
        @(posedge clk);
        chk({vin_on_word, vin_off_word}, 32'h001d001b);
        @(posedge clk);
        chk({31'h0, convert_on}, 32'h1);
        stop_test;
    end

    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        stop_test;
    end
endmodule : testbench
